// ### src/hsl_hub_strap_top.sv
// Hub strap latch, upstream speed indicator and over-current sense with APB
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// [R1] When enabled, the upper and lower non-removable straps are sampled together at release.
// [R2] Pair 00 keeps all ports removable, 01 fixes port 1, 10 ports 1-2, 11 ports 1-3.
// [R3] Configuration select bit 0 is latched from the serial clock pin at reset release.
// [R4] Configuration select bit 1 is latched from the shared indicator pin at reset release.
// [R5] The speed indicator is active high when latched bit 1 is 0, active low when it is 1.
// [R6] The speed indicator is asserted for a high-speed upstream link, negated for full speed.
// [R7] A low level on a port's over-current input marks an over-current for that port.
// [R8] Without the strap enable the non-removable pins are ignored and all ports stay removable.
// [R9] Configuration select bit 2 is latched too and reads 0 where the package lacks the pin.
// [R10] Latched straps stay fixed from release until the next reset.
module hsl_hub_strap_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic nonrem_strap_enable,
  input wire logic cfg_bit2_pin_present,
  input wire logic config_method_bit0,
  input wire logic config_method_bit2,
  input wire logic nonremovable_strap_hi,
  input wire logic nonremovable_strap_lo,
  input wire logic upstream_highspeed_led_in,
  output logic upstream_highspeed_led_out,
  output logic upstream_highspeed_led_oe_n,
  input wire logic upstream_connected,
  input wire logic upstream_at_highspeed,
  input wire logic [6:0] overcurrent_sense_n,
  output logic [2:0] config_method,
  output logic [1:0] nonremovable_strap_pair,
  output logic [2:0] nonremovable_ports,
  output logic [6:0] overcurrent_level
);

  typedef struct packed {
    hsl_pkg::hsl_phase_e phase;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] status;
    logic [7:0] mask;
    logic led_en;
    logic irq;
    logic led_active;
    logic led_out;
    logic led_oe_n;
  } hsl_top_s;

  hsl_top_s r_reg;
  hsl_top_s r_next;
  hsl_pkg::hsl_strap_s strap;
  hsl_pkg::hsl_oc_s oc;

  // Shared pin is read as config bit 1 while the driver is still off
  hsl_strap_latch u_strap (
    .clk(clk),
    .rst(rst),
    .nonrem_strap_en(nonrem_strap_enable),
    .has_cfg_bit2_pin(cfg_bit2_pin_present),
    .cfg_bit0_pin(config_method_bit0),
    .cfg_bit1_pin(upstream_highspeed_led_in),
    .cfg_bit2_pin(config_method_bit2),
    .strap_hi_pin(nonremovable_strap_hi),
    .strap_lo_pin(nonremovable_strap_lo),
    .strap(strap)
  );

  hsl_oc_sense u_oc (
    .clk(clk),
    .rst(rst),
    .overcurrent_sense_n(overcurrent_sense_n),
    .oc(oc)
  );

  function automatic logic addr_hit(input logic [7:0] a);
    case (a)
      hsl_pkg::ADDR_STRAP,
      hsl_pkg::ADDR_STATUS,
      hsl_pkg::ADDR_MASK,
      hsl_pkg::ADDR_LEVEL,
      hsl_pkg::ADDR_CTRL: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  endfunction

  // Strap readback word
  function automatic logic [31:0] strap_word(input hsl_pkg::hsl_strap_s s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[hsl_pkg::STRAP_CFG_LSB +: 3] = s.cfg;
    w[hsl_pkg::STRAP_PAIR_LSB +: 2] = s.nonrem_pair;
    w[hsl_pkg::STRAP_MASK_LSB +: 3] = s.nonrem_mask;
    w[hsl_pkg::STRAP_DONE_BIT] = s.captured;
    strap_word = w;
  endfunction

  logic led_active;
  logic [7:0] events;
  logic [31:0] rd_word;
  logic access;
  logic done;
  logic low_lane;

  always_comb
  begin
    r_next = r_reg;

    // Indicator asserts only for a live high-speed link
    led_active = strap.captured
      & upstream_connected
      & upstream_at_highspeed
      & r_reg.led_en; // [R6]
    r_next.led_active = led_active;

    events = 8'h00;
    events[6:0] = oc.onset; // [R7]
    events[hsl_pkg::EVT_SPEED_BIT] = led_active ^ r_reg.led_active;

    // Sticky status; a fresh event survives a clearing read
    r_next.status = r_reg.status | events;

    rd_word = 32'h0000_0000;
    case (paddr)
      hsl_pkg::ADDR_STRAP:
      begin
        rd_word = strap_word(strap);
      end
      hsl_pkg::ADDR_STATUS:
      begin
        rd_word[7:0] = r_reg.status;
      end
      hsl_pkg::ADDR_MASK:
      begin
        rd_word[7:0] = r_reg.mask;
      end
      hsl_pkg::ADDR_LEVEL:
      begin
        rd_word[6:0] = oc.level; // [R7]
        rd_word[hsl_pkg::LEVEL_HS_BIT] = r_reg.led_active;
      end
      hsl_pkg::ADDR_CTRL:
      begin
        rd_word[hsl_pkg::CTRL_LED_EN_BIT] = r_reg.led_en;
      end
      default:
      begin
        rd_word = 32'h0000_0000;
      end
    endcase

    access = psel & penable;
    done = access & r_reg.pready;
    low_lane = pstrb[0];

    r_next.pready = 1'b0;
    r_next.pslverr = 1'b0;
    r_next.prdata = 32'h0000_0000;

    case (r_reg.phase)
      hsl_pkg::HSL_PH_IDLE:
      begin
        if (access)
        begin
          // Answer one cycle into the access phase
          r_next.pready = 1'b1;
          r_next.pslverr = ~addr_hit(paddr);
          r_next.prdata = pwrite ? 32'h0000_0000 : rd_word;
          r_next.phase = hsl_pkg::HSL_PH_ANSWER;
        end
      end
      hsl_pkg::HSL_PH_ANSWER:
      begin
        if (done)
        begin
          if (pwrite && low_lane)
          begin
            case (paddr)
              hsl_pkg::ADDR_MASK:
              begin
                r_next.mask = pwdata[7:0];
              end
              hsl_pkg::ADDR_CTRL:
              begin
                r_next.led_en = pwdata[hsl_pkg::CTRL_LED_EN_BIT];
              end
              default:
              begin
                r_next.mask = r_reg.mask;
              end
            endcase
          end
          else if (!pwrite && paddr == hsl_pkg::ADDR_STATUS)
          begin
            // Clear only what prdata reported; a bit that landed as it was taken survives
            r_next.status = (r_reg.status & ~r_reg.prdata[7:0]) | events;
          end
        end
        r_next.phase = hsl_pkg::HSL_PH_IDLE;
      end
      default:
      begin
        r_next.phase = hsl_pkg::HSL_PH_IDLE;
      end
    endcase

    r_next.irq = |(r_next.status & r_next.mask);

    // Pin stays released until the strap is safely captured
    r_next.led_oe_n = ~strap.captured;
    if (strap.cfg[1])
    begin
      r_next.led_out = ~led_active; // [R5]
    end
    else
    begin
      r_next.led_out = led_active; // [R5]
    end
    if (!strap.captured)
    begin
      r_next.led_out = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      r_reg.phase <= hsl_pkg::HSL_PH_IDLE;
      r_reg.pready <= 1'b0;
      r_reg.pslverr <= 1'b0;
      r_reg.prdata <= 32'h0000_0000;
      r_reg.status <= hsl_pkg::STATUS_RST;
      r_reg.mask <= hsl_pkg::MASK_RST;
      r_reg.led_en <= hsl_pkg::CTRL_LED_EN_RST;
      r_reg.irq <= 1'b0;
      r_reg.led_active <= 1'b0;
      r_reg.led_out <= 1'b0;
      r_reg.led_oe_n <= 1'b1;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign irq = r_reg.irq;
  assign upstream_highspeed_led_out = r_reg.led_out;
  assign upstream_highspeed_led_oe_n = r_reg.led_oe_n;
  assign config_method = strap.cfg; // [R3]
  assign nonremovable_strap_pair = strap.nonrem_pair; // [R1]
  assign nonremovable_ports = strap.nonrem_mask; // [R2]
  assign overcurrent_level = oc.level;

endmodule // hsl_hub_strap_top
`default_nettype wire

// ### src/hsl_pkg.sv
// Shared constants, types and decode helpers for the hub strap block
package hsl_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_STRAP = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_LEVEL = 8'h0C;
  localparam logic [7:0] ADDR_CTRL = 8'h10;

  // Event layout shared by status and mask
  localparam int EVT_W = 8;
  localparam int EVT_SPEED_BIT = 7;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;

  // Control register: bit 0 enables the speed indicator
  localparam int CTRL_LED_EN_BIT = 0;
  localparam logic CTRL_LED_EN_RST = 1'b1;

  // Strap and level readback field positions
  localparam int STRAP_CFG_LSB = 0;
  localparam int STRAP_PAIR_LSB = 4;
  localparam int STRAP_MASK_LSB = 8;
  localparam int STRAP_DONE_BIT = 16;
  localparam int LEVEL_HS_BIT = 8;

  localparam logic [1:0] NONREM_NONE = 2'h0;
  localparam logic [2:0] NONREM_MASK_RST = 3'h0;
  localparam logic [2:0] CFG_RST = 3'h0;
  localparam logic [6:0] OC_RST = 7'h00;

  typedef enum logic {
    HSL_PH_IDLE,
    HSL_PH_ANSWER
  } hsl_phase_e;

  typedef struct packed {
    logic captured;
    logic [2:0] cfg;
    logic [1:0] nonrem_pair;
    logic [2:0] nonrem_mask;
  } hsl_strap_s;

  typedef struct packed {
    logic [6:0] level;
    logic [6:0] onset;
  } hsl_oc_s;

  // Strap pair to non-removable mask of ports 3..1
  function automatic logic [2:0] nonrem_decode(input logic [1:0] pair);
    case (pair)
      2'h1: nonrem_decode = 3'h1;
      2'h2: nonrem_decode = 3'h3;
      2'h3: nonrem_decode = 3'h7;
      default: nonrem_decode = 3'h0;
    endcase
  endfunction

endpackage

// ### src/hsl_strap_latch.sv
// Capture of configuration and non-removable straps at reset release
`timescale 1ns/100ps
`default_nettype none
module hsl_strap_latch (
  input wire logic clk,
  input wire logic rst,
  input wire logic nonrem_strap_en,
  input wire logic has_cfg_bit2_pin,
  input wire logic cfg_bit0_pin,
  input wire logic cfg_bit1_pin,
  input wire logic cfg_bit2_pin,
  input wire logic strap_hi_pin,
  input wire logic strap_lo_pin,
  output hsl_pkg::hsl_strap_s strap
);

  hsl_pkg::hsl_strap_s strap_reg;
  hsl_pkg::hsl_strap_s strap_next;

  // Pins are sampled at the first edge after release, never by the reset itself
  always_comb
  begin
    strap_next = strap_reg;
    if (!strap_reg.captured)
    begin
      strap_next.captured = 1'b1;
      strap_next.cfg[0] = cfg_bit0_pin; // [R3]
      strap_next.cfg[1] = cfg_bit1_pin; // [R4]
      strap_next.cfg[2] = cfg_bit2_pin & has_cfg_bit2_pin; // [R9]
      if (nonrem_strap_en)
      begin
        strap_next.nonrem_pair = {strap_hi_pin, strap_lo_pin}; // [R1]
      end
      else
      begin
        strap_next.nonrem_pair = hsl_pkg::NONREM_NONE; // [R8]
      end
      strap_next.nonrem_mask = hsl_pkg::nonrem_decode(strap_next.nonrem_pair); // [R2]
    end
  end

  // Once captured nothing rewrites the straps until reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      strap_reg.captured <= 1'b0;
      strap_reg.cfg <= hsl_pkg::CFG_RST;
      strap_reg.nonrem_pair <= hsl_pkg::NONREM_NONE;
      strap_reg.nonrem_mask <= hsl_pkg::NONREM_MASK_RST;
    end
    else
    begin
      strap_reg <= strap_next; // [R10]
    end
  end

  assign strap = strap_reg;

endmodule // hsl_strap_latch
`default_nettype wire

// ### src/hsl_oc_sense.sv
// Per-port over-current level and onset detection
`timescale 1ns/100ps
`default_nettype none
module hsl_oc_sense (
  input wire logic clk,
  input wire logic rst,
  input wire logic [6:0] overcurrent_sense_n,
  output hsl_pkg::hsl_oc_s oc
);

  hsl_pkg::hsl_oc_s oc_reg;
  hsl_pkg::hsl_oc_s oc_next;

  // Low input means over-current; onset is a one-cycle pulse
  always_comb
  begin
    oc_next = oc_reg;
    oc_next.level = ~overcurrent_sense_n; // [R7]
    oc_next.onset = ~overcurrent_sense_n & ~oc_reg.level; // [R7]
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      oc_reg.level <= hsl_pkg::OC_RST;
      oc_reg.onset <= hsl_pkg::OC_RST;
    end
    else
    begin
      oc_reg <= oc_next;
    end
  end

  assign oc = oc_reg;

endmodule // hsl_oc_sense
`default_nettype wire

// ### testbench/hsl_asserts.sv
// Port-level checks for the hub strap block
`timescale 1ns/100ps
`default_nettype none
module hsl_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic upstream_highspeed_led_out,
  input wire logic upstream_highspeed_led_oe_n,
  input wire logic upstream_connected,
  input wire logic upstream_at_highspeed,
  input wire logic [6:0] overcurrent_sense_n,
  input wire logic [2:0] config_method,
  input wire logic [1:0] nonremovable_strap_pair,
  input wire logic [2:0] nonremovable_ports,
  input wire logic [6:0] overcurrent_level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic [1:0] p = nonremovable_strap_pair;
  port_decode_a: assert property (nonremovable_ports == {&p, p[1], |p})
    else $error("non-removable mask disagrees with pair");
  strap_hold_a: assert property (!$past(rst) && !$past(rst, 2) |->
    $stable({config_method, p})) else $error("latched strap moved");
  pin_release_a: assert property ($past(rst) || $past(rst, 2) |->
    upstream_highspeed_led_oe_n) else $error("indicator pin driven during capture");
  led_level_a: assert property (!$past(rst) && !$past(rst, 2) && !$past(rst, 3) &&
    (upstream_highspeed_led_out != config_method[1]) |-> !upstream_highspeed_led_oe_n &&
    $past(upstream_connected && upstream_at_highspeed)) else $error("indicator level wrong");
  oc_level_a: assert property (!$past(rst) |->
    overcurrent_level == ~$past(overcurrent_sense_n)) else $error("over-current level wrong");
  ack_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  ack_wait_a: assert property (psel && penable && !pready |=> pready) else $error("no answer");
  ack_cause_a: assert property (pready |-> $past(psel && penable)) else $error("stray pready");
  err_idle_a: assert property (!pready |-> !pslverr && prdata == 32'h0)
    else $error("pslverr or prdata outside answer");
  cover property (pready && pslverr);
  cover property (nonremovable_ports == 3'h7);
  cover property (upstream_highspeed_led_out && !upstream_highspeed_led_oe_n);
endmodule // hsl_asserts
bind hsl_hub_strap_top hsl_asserts chk_u (.clk, .rst, .psel, .penable, .prdata, .pready,
  .pslverr, .upstream_highspeed_led_out, .upstream_highspeed_led_oe_n, .upstream_connected,
  .upstream_at_highspeed, .overcurrent_sense_n, .config_method, .nonremovable_strap_pair,
  .nonremovable_ports, .overcurrent_level);
`default_nettype wire

// ### testbench/hsl_board.sv
// Board strap resistors and per-port current monitors
`timescale 1ns/100ps
`default_nettype none
module hsl_board (
  input wire logic [2:0] cfg_s,
  input wire logic [1:0] pair_s,
  input wire logic [6:0] fault,
  input wire logic led_out,
  input wire logic led_oe_n,
  output logic [4:0] pins,
  output logic [6:0] ocs_n
);
  // Resistor sets the shared pin only while the hub lets go
  assign pins = {cfg_s[2], cfg_s[0], pair_s, led_oe_n ? cfg_s[1] : led_out};
  // Monitor pulls low on a fault; pull-up otherwise
  assign ocs_n = ~fault;
endmodule // hsl_board
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the hub strap block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, q1;
  logic [3:0] strb = 4'hF;
  logic pready, pslverr, irq, e, led_out, led_oe_n;
  logic en = 1'b0, pres = 1'b1, upstream_connected = 1'b0, upstream_at_highspeed = 1'b0;
  logic [2:0] cfg_s = 3'h0, config_method, nonremovable_ports, xc;
  logic [1:0] pair_s = 2'h0, nonremovable_strap_pair, xp;
  logic [6:0] fault = 7'h00, overcurrent_sense_n, overcurrent_level;
  logic [4:0] pins;
  logic [2:0] mtab [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
  int bad_count = 0, n_tests = 0;
  always #2 clk = ~clk;
  hsl_board board_u (.cfg_s, .pair_s, .fault, .led_out, .led_oe_n, .pins,
    .ocs_n(overcurrent_sense_n));
  hsl_hub_strap_top dut_u (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(strb), .prdata, .pready, .pslverr, .irq, .nonrem_strap_enable(en),
    .cfg_bit2_pin_present(pres), .config_method_bit0(pins[3]), .config_method_bit2(pins[4]),
    .nonremovable_strap_hi(pins[2]), .nonremovable_strap_lo(pins[1]),
    .upstream_highspeed_led_in(pins[0]), .upstream_highspeed_led_out(led_out),
    .upstream_highspeed_led_oe_n(led_oe_n), .upstream_connected, .upstream_at_highspeed,
    .overcurrent_sense_n, .config_method, .nonremovable_strap_pair, .nonremovable_ports,
    .overcurrent_level);
  task automatic final_report;
    if (bad_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      bad_count++;
      final_report();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following setup never rewrites psel in this time step
    @(posedge clk);
  endtask
  initial
  begin
    for (int i = 0; i < 8; i++)
    begin
      xp = i[2] ? 2'h0 : 2'(i);
      xc = (i == 7) ? 3'h3 : 3'(i);
      en <= !i[2];
      pres <= (i != 7);
      cfg_s <= 3'(i);
      pair_s <= 2'(i);
      upstream_at_highspeed <= 1'b0;
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      chk(config_method, xc);
      chk(nonremovable_strap_pair, xp);
      chk(nonremovable_ports, mtab[xp]);
      cfg_s <= ~cfg_s;
      pair_s <= ~pair_s;
      repeat (2) @(posedge clk);
      chk({nonremovable_strap_pair, config_method}, {xp, xc});
      apb(1'b0, 8'h00, 32'h0);
      chk(q, {15'h0, 1'b1, 5'h0, mtab[xp], 2'h0, xp, 1'b0, xc});
      upstream_connected <= 1'b1;
      upstream_at_highspeed <= 1'b1;
      repeat (3) @(posedge clk);
      chk({led_oe_n, led_out}, {1'b0, ~xc[1]});
      upstream_at_highspeed <= 1'b0;
      repeat (3) @(posedge clk);
      chk(led_out, xc[1]);
    end
    apb(1'b0, 8'h04, 32'h0);
    apb(1'b1, 8'h08, 32'h1);
    fault <= 7'h01;
    repeat (5) @(posedge clk);
    chk({irq, overcurrent_level}, {1'b1, 7'h01});
    apb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    apb(1'b1, 8'h08, 32'h0);
    fault <= 7'h08;
    repeat (5) @(posedge clk);
    chk({irq, overcurrent_level}, {1'b0, 7'h08});
    apb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h8);
    apb(1'b0, 8'h14, 32'h0);
    chk({e, q}, {1'b1, 32'h0});
    // Onset lands while the clearing read is in flight: it must not be lost
    fault <= 7'h18;
    apb(1'b0, 8'h04, 32'h0);
    q1 = q;
    apb(1'b0, 8'h04, 32'h0);
    chk(q1 | q, 32'h10);
    strb <= 4'hE;
    apb(1'b1, 8'h08, 32'hFF);
    strb <= 4'hF;
    apb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, 8'h10, 32'h0);
    upstream_at_highspeed <= 1'b1;
    repeat (3) @(posedge clk);
    chk(led_out, xc[1]);
    apb(1'b0, 8'h0C, 32'h0);
    chk(q, 32'h18);
    apb(1'b1, 8'h10, 32'h1);
    repeat (3) @(posedge clk);
    apb(1'b0, 8'h0C, 32'h0);
    chk(q, 32'h118);
    chk(led_out, !xc[1]);
    apb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h80);
    apb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h1);
    final_report();
  end
endmodule // testbench
`default_nettype wire
